// [time_shared_bcd_io_pkg.sv]
// shared constants, types and decode functions of the time-shared bcd i/o block
package time_shared_bcd_io_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_TIME_NS    = 1000000;
  localparam int MS_CYCLES     = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OP_CYCLE_CLKS = 250;

  localparam logic [7:0] SWITCH_TIME_RST_MS = 8'h14;
  localparam logic [4:0] SIGNED_CODE_OFFSET = 5'h10;
  localparam logic [3:0] MAX_DIGITS         = 4'h8;
  localparam logic [3:0] WORD_DIGITS        = 4'h4;
  localparam logic [3:0] BCD_MAX            = 4'h9;

  localparam logic [7:0] ADDR_DISP_LO     = 8'h00;
  localparam logic [7:0] ADDR_DISP_HI     = 8'h04;
  localparam logic [7:0] ADDR_DISP_CFG    = 8'h08;
  localparam logic [7:0] ADDR_SCAN_CFG    = 8'h0C;
  localparam logic [7:0] ADDR_SWITCH_TIME = 8'h10;
  localparam logic [7:0] ADDR_SCAN_LO     = 8'h14;
  localparam logic [7:0] ADDR_SCAN_HI     = 8'h18;
  localparam logic [7:0] ADDR_STATUS      = 8'h1C;

  localparam int CFG_CODE_LSB   = 0;
  localparam int CFG_POL_LSB    = 8;
  localparam int CFG_EN_BIT     = 12;
  localparam int SCAN_START_BIT = 8;
  localparam int ST_SCAN_BUSY   = 0;
  localparam int ST_SCAN_DONE   = 1;
  localparam int ST_SCAN_BAD    = 2;
  localparam int ST_DISP_BUSY   = 3;

  localparam logic [4:0] DISP_CODE_RST = 5'h04;
  localparam logic [1:0] DISP_POL_RST  = 2'h0;
  localparam logic [4:0] SCAN_CODE_RST = 5'h04;

  typedef enum logic [1:0] {
    DISP_IDLE   = 2'b00,
    DISP_SETUP  = 2'b01,
    DISP_STROBE = 2'b10,
    DISP_HOLD   = 2'b11
  } disp_state_type;

  typedef enum logic [0:0] {
    SCAN_IDLE   = 1'b0,
    SCAN_SETTLE = 1'b1
  } scan_state_type;

  typedef struct packed {
    logic       sign;
    logic [3:0] data;
    logic [7:0] strobe;
  } disp_pins_type;

  typedef struct packed {
    logic [3:0] digits;
    logic       signed_mode;
  } digit_code_type;

  // digits == 0 marks a code that neither mode accepts
  function automatic digit_code_type decode_digits(input logic [4:0] code);
    digit_code_type r;
    r.digits      = 4'h0;
    r.signed_mode = 1'b0;
    if (code >= 5'h01 && code <= {1'b0, MAX_DIGITS}) begin
      r.digits = code[3:0];
    end else if (code > SIGNED_CODE_OFFSET && code <= SIGNED_CODE_OFFSET + {1'b0, MAX_DIGITS}) begin
      r.digits      = 4'(code - SIGNED_CODE_OFFSET);
      r.signed_mode = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [26:0] mul10(input logic [26:0] w);
    logic [30:0] x;
    x = {4'h0, w};
    return 27'((x << 3) + (x << 1));
  endfunction
endpackage

// [bin_to_bcd8.sv]
// combinational binary to eight-digit bcd converter
`timescale 1ns/1ns
module bin_to_bcd8
  import time_shared_bcd_io_pkg::*;
(
  input  wire logic [26:0] bin_in,
  output logic      [31:0] bcd_out
);
  logic [35:0] acc;

  // shift-add-3; a ninth digit absorbs values past eight digits, only eight are shown
  always_comb begin
    acc = 36'h0;
    for (int i = 26; i >= 0; i--) begin
      for (int d = 0; d < 9; d++) begin
        if (acc[d*4 +: 4] > 4'h4) begin
          acc[d*4 +: 4] = 4'(acc[d*4 +: 4] + 4'h3);
        end
      end
      acc = {acc[34:0], bin_in[i]};
    end
    bcd_out = acc[31:0];
  end
endmodule

// [time_shared_bcd_io.sv]
// time-shared latched 7-segment display driver and multiplexed digit switch reader
`timescale 1ns/1ns
// Operation
// [R01] switch select held for programmable switching time before sampling, reset 20 ms
// [R02] switching time register accepts small values such as 7 ms
// [R03] external controller feeding switches needs switching time longer than its delay
// [R04] unsigned read uses 4 inputs, signed 5; one select per digit
// [R05] four bcd lines weighted 1,2,4,8 then strobes from least digit upward
// [R06] unsigned codes 1-4 use low word, 5-8 use word pair
// [R07] strobes driven only for the configured number of digits
// [R08] binary value converted to bcd and shown one digit at a time
// [R09] one step per operation cycle; four digits refresh in 12 cycles
// [R10] at most two display channels may exist
// [R11] signed mode adds sign line, high for negative values
// [R12] signed codes are digits plus 16, 17 to 24
// [R13] data polarity selects high or low level for set bcd bits
// [R14] display holds data while strobe sits at its active level
// [R15] polarity code 0..3 maps data and strobe polarity bits
// [R16] sampled bcd digits assembled into binary and stored
// [R17] signed read takes sign on first input, high is negative
// [R18] data set up before its strobe; one strobe at a time
module time_shared_bcd_io
  import time_shared_bcd_io_pkg::*;
#(
  parameter int OP_DIV           = OP_CYCLE_CLKS,
  parameter int MS_DIV           = MS_CYCLES,
  parameter int DISPLAY_CHANNELS = 1
) (
  input  wire logic    [7:0]  addr_in,
  input  wire logic           clk_sys_in,
  input  wire logic           rst_in,
  input  wire logic    [31:0] wr_data_in,
  input  wire logic           wr_in,
  input  wire logic           rd_in,
  output logic         [31:0] rd_data_out,
  input  wire logic    [4:0]  switch_in,
  output logic         [7:0]  scan_select_out,
  output disp_pins_type       seg_display_out
);
  generate
    if (OP_DIV < 1 || OP_DIV > 65536 || MS_DIV < 1 || MS_DIV > 65536) begin : g_bad_div
      $error("divider parameter out of range");
    end
    if (DISPLAY_CHANNELS < 1 || DISPLAY_CHANNELS > 2) begin : g_bad_chan // [R10]
      $error("display channel count must be 1 or 2");
    end
  endgenerate

  localparam logic [15:0] OP_LAST = 16'(OP_DIV - 1);
  localparam logic [15:0] MS_LAST = 16'(MS_DIV - 1);

  // operation cycle divider
  logic [15:0] op_cnt_q, op_cnt_d;
  logic        op_tick_q, op_tick_d;

  always_comb begin
    op_tick_d = (op_cnt_q == OP_LAST);
    op_cnt_d  = op_tick_d ? 16'h0000 : 16'(op_cnt_q + 16'h0001);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      op_cnt_q  <= 16'h0000;
      op_tick_q <= 1'b0;
    end else begin
      op_cnt_q  <= op_cnt_d;
      op_tick_q <= op_tick_d;
    end
  end

  // register file
  logic [15:0]    disp_lo_q, disp_lo_d, disp_hi_q, disp_hi_d;
  logic [4:0]     disp_code_q, disp_code_d, scan_code_q, scan_code_d;
  logic [1:0]     disp_pol_q, disp_pol_d;
  logic           disp_en_q, disp_en_d;
  logic [7:0]     sw_time_q, sw_time_d;
  logic [31:0]    rd_data_q, rd_data_d;
  logic           scan_start, status_rd;
  disp_state_type disp_q, disp_d;
  scan_state_type scan_q, scan_d;
  logic [15:0]    scan_lo_q, scan_lo_d, scan_hi_q, scan_hi_d;
  logic           done_q, done_d, bad_q, bad_d;

  assign status_rd  = rd_in && (addr_in == ADDR_STATUS);
  assign scan_start = wr_in && (addr_in == ADDR_SCAN_CFG) && wr_data_in[SCAN_START_BIT]
                      && (scan_q == SCAN_IDLE) && (decode_digits(wr_data_in[4:0]).digits != 4'h0);

  always_comb begin
    disp_lo_d   = disp_lo_q;
    disp_hi_d   = disp_hi_q;
    disp_code_d = disp_code_q;
    disp_pol_d  = disp_pol_q;
    disp_en_d   = disp_en_q;
    scan_code_d = scan_code_q;
    sw_time_d   = sw_time_q;
    rd_data_d   = 32'h0000_0000;
    if (wr_in) begin
      case (addr_in)
        ADDR_DISP_LO: disp_lo_d = wr_data_in[15:0];
        ADDR_DISP_HI: disp_hi_d = wr_data_in[15:0];
        ADDR_DISP_CFG: begin
          disp_code_d = wr_data_in[CFG_CODE_LSB +: 5];
          disp_pol_d  = wr_data_in[CFG_POL_LSB +: 2]; // [R15]
          disp_en_d   = wr_data_in[CFG_EN_BIT];
        end
        // code is frozen while a scan runs
        ADDR_SCAN_CFG: if (scan_q == SCAN_IDLE) begin
          scan_code_d = wr_data_in[CFG_CODE_LSB +: 5];
        end
        ADDR_SWITCH_TIME: sw_time_d = wr_data_in[7:0]; // [R02]
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        ADDR_DISP_LO:     rd_data_d[15:0] = disp_lo_q;
        ADDR_DISP_HI:     rd_data_d[15:0] = disp_hi_q;
        ADDR_DISP_CFG: begin
          rd_data_d[CFG_CODE_LSB +: 5] = disp_code_q;
          rd_data_d[CFG_POL_LSB +: 2]  = disp_pol_q;
          rd_data_d[CFG_EN_BIT]        = disp_en_q;
        end
        ADDR_SCAN_CFG:    rd_data_d[CFG_CODE_LSB +: 5] = scan_code_q;
        ADDR_SWITCH_TIME: rd_data_d[7:0] = sw_time_q;
        ADDR_SCAN_LO:     rd_data_d[15:0] = scan_lo_q;
        ADDR_SCAN_HI:     rd_data_d[15:0] = scan_hi_q;
        ADDR_STATUS: begin
          rd_data_d[ST_SCAN_BUSY] = (scan_q != SCAN_IDLE);
          rd_data_d[ST_SCAN_DONE] = done_q;
          rd_data_d[ST_SCAN_BAD]  = bad_q;
          rd_data_d[ST_DISP_BUSY] = (disp_q != DISP_IDLE);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      disp_lo_q   <= 16'h0000;
      disp_hi_q   <= 16'h0000;
      disp_code_q <= DISP_CODE_RST;
      disp_pol_q  <= DISP_POL_RST;
      disp_en_q   <= 1'b0;
      scan_code_q <= SCAN_CODE_RST;
      sw_time_q   <= SWITCH_TIME_RST_MS; // [R01]
      rd_data_q   <= 32'h0000_0000;
    end else begin
      disp_lo_q   <= disp_lo_d;
      disp_hi_q   <= disp_hi_d;
      disp_code_q <= disp_code_d;
      disp_pol_q  <= disp_pol_d;
      disp_en_q   <= disp_en_d;
      scan_code_q <= scan_code_d;
      sw_time_q   <= sw_time_d;
      rd_data_q   <= rd_data_d;
    end
  end

  // display value path
  digit_code_type dcode;
  logic [31:0]    dwide, dmag;
  logic           dneg_now;
  logic [31:0]    bcd_now;

  assign dcode    = decode_digits(disp_code_q); // [R06] [R12]
  assign dwide    = (dcode.digits > WORD_DIGITS) ? {disp_hi_q, disp_lo_q}
                  : (dcode.signed_mode ? {{16{disp_lo_q[15]}}, disp_lo_q} : {16'h0000, disp_lo_q});
  assign dneg_now = dcode.signed_mode && dwide[31];
  assign dmag     = dneg_now ? 32'(~dwide + 32'h0000_0001) : dwide;

  bin_to_bcd8 u_bcd (
    .bin_in  (dmag[26:0]),
    .bcd_out (bcd_now)
  ); // [R08]

  // display sequencer: setup, strobe, hold per digit
  logic [2:0]    dig_q, dig_d;
  logic [3:0]    dnd_q, dnd_d;
  logic [31:0]   bcd_q, bcd_d;
  logic          dsgn_q, dsgn_d, dneg_q, dneg_d;
  disp_pins_type pins_q, pins_d;
  logic          dlast, disp_load;
  logic [3:0]    nib_d, nib_q;

  assign dlast     = ({1'b0, dig_q} == 4'(dnd_q - 4'h1));
  assign disp_load = op_tick_q && disp_en_q && (dcode.digits != 4'h0)
                     && (disp_q == DISP_IDLE || (disp_q == DISP_HOLD && dlast));
  assign nib_q     = bcd_q[{dig_q, 2'b00} +: 4];

  always_comb begin
    disp_d = disp_q;
    dig_d  = dig_q;
    dnd_d  = dnd_q;
    bcd_d  = bcd_q;
    dsgn_d = dsgn_q;
    dneg_d = dneg_q;
    if (op_tick_q) begin // [R09]
      unique case (disp_q)
        DISP_IDLE:   ;
        DISP_SETUP:  disp_d = DISP_STROBE;
        DISP_STROBE: disp_d = DISP_HOLD;
        DISP_HOLD: begin
          if (!dlast) begin
            dig_d  = 3'(dig_q + 3'h1);
            disp_d = DISP_SETUP;
          end else begin
            disp_d = DISP_IDLE;
          end
        end
      endcase
    end
    // snapshot per refresh so a mid-refresh write never mixes two values
    if (disp_load) begin
      bcd_d  = bcd_now;
      dnd_d  = dcode.digits; // [R07]
      dsgn_d = dcode.signed_mode;
      dneg_d = dneg_now;
      dig_d  = 3'h0;
      disp_d = DISP_SETUP;
    end
    nib_d       = bcd_d[{dig_d, 2'b00} +: 4];
    pins_d.data = ((disp_d == DISP_IDLE) ? 4'h0 : nib_d) ^ {4{disp_pol_q[1]}}; // [R05] [R13]
    // strobe pulses to its active level only in the strobe step, data already stable
    pins_d.strobe = {8{disp_pol_q[0]}}; // [R14] [R15]
    if (disp_d == DISP_STROBE) begin
      pins_d.strobe[dig_d] = ~disp_pol_q[0]; // [R18]
    end
    pins_d.sign = (disp_d != DISP_IDLE) && dsgn_d && dneg_d; // [R11]
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      disp_q <= DISP_IDLE;
      dig_q  <= 3'h0;
      dnd_q  <= 4'h0;
      bcd_q  <= 32'h0000_0000;
      dsgn_q <= 1'b0;
      dneg_q <= 1'b0;
      pins_q <= '0;
    end else begin
      disp_q <= disp_d;
      dig_q  <= dig_d;
      dnd_q  <= dnd_d;
      bcd_q  <= bcd_d;
      dsgn_q <= dsgn_d;
      dneg_q <= dneg_d;
      pins_q <= pins_d;
    end
  end

  // switch scanner
  digit_code_type scode;
  logic [2:0]  sidx_q, sidx_d;
  logic [3:0]  snd_q, snd_d;
  logic        ssgn_q, ssgn_d, sneg_d;
  logic [7:0]  sel_q, sel_d, time_q, time_d, left_q, left_d, eff_time;
  logic [15:0] ms_cnt_q, ms_cnt_d;
  logic [26:0] acc_q, acc_d, weight_q, weight_d;
  logic [30:0] prod;
  logic [31:0] result;
  logic [3:0]  nib_in;
  logic        scan_finish;

  assign scode    = decode_digits(wr_data_in[4:0]);
  assign eff_time = (sw_time_q == 8'h00) ? 8'h01 : sw_time_q;
  assign nib_in   = ssgn_q ? switch_in[4:1] : switch_in[3:0]; // [R04] [R17]
  assign prod     = {4'h0, weight_q} * {27'h0, nib_in};

  always_comb begin
    scan_d      = scan_q;
    sidx_d      = sidx_q;
    snd_d       = snd_q;
    ssgn_d      = ssgn_q;
    sel_d       = sel_q;
    time_d      = time_q;
    left_d      = left_q;
    ms_cnt_d    = ms_cnt_q;
    acc_d       = acc_q;
    weight_d    = weight_q;
    bad_d       = bad_q;
    scan_lo_d   = scan_lo_q;
    scan_hi_d   = scan_hi_q;
    scan_finish = 1'b0;
    sneg_d      = 1'b0;
    result      = 32'h0000_0000;
    unique case (scan_q)
      SCAN_IDLE: if (scan_start) begin
        scan_d   = SCAN_SETTLE;
        snd_d    = scode.digits;
        ssgn_d   = scode.signed_mode;
        sidx_d   = 3'h0;
        sel_d    = 8'h01;
        time_d   = eff_time;
        left_d   = eff_time;
        ms_cnt_d = MS_LAST;
        acc_d    = 27'h0;
        weight_d = 27'h1;
        bad_d    = 1'b0;
      end
      SCAN_SETTLE: begin
        if (ms_cnt_q != 16'h0000) begin
          ms_cnt_d = 16'(ms_cnt_q - 16'h0001);
        end else begin
          ms_cnt_d = MS_LAST;
          if (left_q != 8'h01) begin
            left_d = 8'(left_q - 8'h01); // [R01]
          end else begin
            acc_d    = 27'(acc_q + 27'(prod)); // [R16]
            weight_d = mul10(weight_q);
            bad_d    = bad_q || (nib_in > BCD_MAX);
            if ({1'b0, sidx_q} == 4'(snd_q - 4'h1)) begin
              scan_finish = 1'b1;
              scan_d      = SCAN_IDLE;
              sel_d       = 8'h00;
              sneg_d      = ssgn_q && switch_in[0]; // [R17]
              result      = sneg_d ? 32'(-{5'h00, acc_d}) : {5'h00, acc_d};
              // non-bcd digits leave the previous result in place
              if (!bad_d) begin
                scan_lo_d = result[15:0];
                if (snd_q > WORD_DIGITS) begin
                  scan_hi_d = result[31:16]; // [R06]
                end
              end
            end else begin
              sidx_d = 3'(sidx_q + 3'h1);
              sel_d  = 8'(sel_q << 1);
              left_d = time_q;
            end
          end
        end
      end
    endcase
    done_d = scan_finish ? 1'b1 : (status_rd ? 1'b0 : done_q);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      scan_q    <= SCAN_IDLE;
      sidx_q    <= 3'h0;
      snd_q     <= 4'h0;
      ssgn_q    <= 1'b0;
      sel_q     <= 8'h00;
      time_q    <= 8'h01;
      left_q    <= 8'h01;
      ms_cnt_q  <= 16'h0000;
      acc_q     <= 27'h0;
      weight_q  <= 27'h1;
      bad_q     <= 1'b0;
      done_q    <= 1'b0;
      scan_lo_q <= 16'h0000;
      scan_hi_q <= 16'h0000;
    end else begin
      scan_q    <= scan_d;
      sidx_q    <= sidx_d;
      snd_q     <= snd_d;
      ssgn_q    <= ssgn_d;
      sel_q     <= sel_d;
      time_q    <= time_d;
      left_q    <= left_d;
      ms_cnt_q  <= ms_cnt_d;
      acc_q     <= acc_d;
      weight_q  <= weight_d;
      bad_q     <= bad_d;
      done_q    <= done_d;
      scan_lo_q <= scan_lo_d;
      scan_hi_q <= scan_hi_d;
    end
  end

  assign rd_data_out     = rd_data_q;
  assign scan_select_out = sel_q;
  assign seg_display_out = pins_q;

  // checks
  logic [31:0] hold_cnt_q;
  logic [31:0] hold_need;

  assign hold_need = 32'(time_q) * 32'(MS_DIV);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || sel_d != sel_q) begin
      hold_cnt_q <= 32'h0000_0000;
    end else begin
      hold_cnt_q <= 32'(hold_cnt_q + 32'h0000_0001);
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  chk_one_strobe_only: assert property ( // [R18]
    $onehot0(seg_display_out.strobe ^ {8{$past(disp_pol_q[0])}}))
    else $error("more than one strobe active");
  chk_setup_before_strobe: assert property ( // [R18]
    ($rose(disp_q == DISP_STROBE) && $stable(disp_pol_q))
      |-> seg_display_out.data == $past(seg_display_out.data))
    else $error("data changed as strobe went active");
  chk_digit_step_pace: assert property ( // [R09]
    (disp_q == DISP_SETUP && op_tick_q) |=> disp_q == DISP_STROBE)
    else $error("digit setup step did not advance to strobe");
  chk_strobe_step_pace: assert property ( // [R09]
    (disp_q == DISP_STROBE && op_tick_q) |=> disp_q == DISP_HOLD)
    else $error("digit strobe step did not advance to hold");
  chk_state_on_tick: assert property ( // [R09]
    (disp_q != $past(disp_q)) |-> $past(op_tick_q))
    else $error("display state moved without an operation cycle");
  chk_data_polarity_map: assert property ( // [R13]
    (disp_q == DISP_STROBE && $stable(disp_pol_q) && $stable(dig_q))
      |-> seg_display_out.data == ($past(nib_q) ^ {4{$past(disp_pol_q[1])}}))
    else $error("bcd data level does not follow data polarity");
  chk_strobe_in_range: assert property ( // [R07]
    ((seg_display_out.strobe ^ {8{$past(disp_pol_q[0])}}) >> $past(dnd_q)) == 8'h00)
    else $error("strobe beyond configured digit count");
  chk_sign_line_cause: assert property ( // [R11]
    seg_display_out.sign |-> (dsgn_q && dneg_q && disp_q != DISP_IDLE))
    else $error("sign line without signed negative value");
  chk_signed_code_map: assert property ( // [R12]
    disp_load |=> dsgn_q == ($past(disp_code_q) > SIGNED_CODE_OFFSET))
    else $error("signed mode not taken from code above 16");
  chk_select_onehot: assert property ( // [R04]
    $onehot0(scan_select_out))
    else $error("more than one digit select active");
  chk_switch_hold_time: assert property ( // [R01]
    ($past(scan_select_out) != 8'h00 && scan_select_out != $past(scan_select_out))
      |-> 32'($past(hold_cnt_q) + 32'h0000_0002) >= $past(hold_need))
    else $error("digit select released before switching time");
  chk_done_set_wins: assert property ( // [R16]
    (scan_finish && status_rd) |=> done_q)
    else $error("scan done lost against status read");
  chk_result_stored: assert property ( // [R16]
    (scan_finish && !bad_d) |=> scan_lo_q == $past(result[15:0]))
    else $error("scan result not stored");
endmodule

// [thumbwheel_switch_model.sv]
// model of a bank of bcd thumbwheel switches answering the digit selects
`timescale 1ns/1ns
module thumbwheel_switch_model (
  input  wire logic [7:0]  scan_select_in,
  input  wire logic        signed_in,
  input  wire logic        neg_in,
  input  wire logic [31:0] digits_in,
  output logic      [4:0]  switch_out
);
  logic [4:0] last_q = 5'h00;

  // unselected contacts float: show the inverse so a stale sample cannot pass
  always_comb begin
    switch_out = ~last_q;
    for (int i = 0; i < 8; i++) begin
      if (scan_select_in[i]) begin
        switch_out = signed_in ? {digits_in[4*i+:4], neg_in} : {1'b0, digits_in[4*i+:4]};
      end
    end
  end

  always @(switch_out) begin
    if (scan_select_in != 8'h00) begin
      last_q = switch_out;
    end
  end
endmodule

// [test_time_shared_bcd_io.sv]
// self-checking bench for the time-shared bcd display driver and switch reader
`timescale 1ns/1ns
module test_time_shared_bcd_io;
  import time_shared_bcd_io_pkg::*;
  localparam int OPD = 2;
  localparam int MSD = 4;
  logic          clk_sys_in = 1'b0;
  logic          rst_in     = 1'b1;
  logic [7:0]    addr_in    = 8'h00;
  logic [31:0]   wr_data_in = 32'h0;
  logic          wr_in      = 1'b0;
  logic          rd_in      = 1'b0;
  logic [31:0]   rd_data_out;
  logic [4:0]    switch_in;
  logic [7:0]    scan_select_out;
  disp_pins_type seg_display_out;
  logic          sw_signed  = 1'b0;
  logic          sw_neg     = 1'b0;
  logic [31:0]   sw_digits  = 32'h0;
  logic [31:0]   rv;
  int            errors     = 0;
  int            cmp_count  = 0;
  int            cycles     = 0;

  always #20 clk_sys_in = ~clk_sys_in;

  time_shared_bcd_io #(.OP_DIV(OPD), .MS_DIV(MSD), .DISPLAY_CHANNELS(1)) time_shared_bcd_io_i (
    .addr_in(addr_in), .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .switch_in(switch_in),
    .scan_select_out(scan_select_out), .seg_display_out(seg_display_out));

  thumbwheel_switch_model thumbwheel_switch_model_i (
    .scan_select_in(scan_select_out), .signed_in(sw_signed), .neg_in(sw_neg),
    .digits_in(sw_digits), .switch_out(switch_in));

  task automatic summarize;
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a hang is cut well beyond the few hundred cycles the tests need
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge clk_sys_in);
    wr_in      <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in   <= 1'b0;
    @(negedge clk_sys_in);
    d = rd_data_out;
  endtask

  task automatic t_reset;
    chk("pins", 32'h0, {11'h0, seg_display_out, scan_select_out});
    rd(ADDR_DISP_CFG, rv);
    chk("disp cfg", 32'h4, rv);
    rd(ADDR_SWITCH_TIME, rv);
    chk("switch time", 32'h14, rv);
    rd(ADDR_STATUS, rv);
    chk("status", 32'h0, rv);
    rd(8'h20, rv);
    chk("unmapped", 32'h0, rv);
  endtask

  // stops any refresh, loads the value and watches one full refresh at the latch points
  task automatic t_disp(input logic [4:0] code, input logic [1:0] pol, input logic [31:0] val,
                        input logic [31:0] bcd, input logic neg);
    int         n;
    int         k;
    int         last;
    logic [7:0] mask;
    logic [7:0] act;
    logic [7:0] pact;
    logic [3:0] dat;
    logic [3:0] pdat;
    n = (code > 5'h10) ? int'(code) - 16 : int'(code);
    mask = 8'((1 << n) - 1);
    wr(ADDR_DISP_CFG, 32'h0);
    rv = 32'hF;
    for (int i = 0; i < 50 && rv[ST_DISP_BUSY] !== 1'b0; i++) begin
      rd(ADDR_STATUS, rv);
    end
    wr(ADDR_DISP_LO, {16'h0, val[15:0]});
    wr(ADDR_DISP_HI, {16'h0, val[31:16]});
    wr(ADDR_DISP_CFG, {19'h0, 1'b1, 2'h0, pol, 3'h0, code});
    // pins take a new polarity one clock late; watching earlier shows false strobes
    @(posedge clk_sys_in);
    k = 0;
    last = 0;
    pact = 8'h00;
    pdat = 4'h0;
    for (int c = 0; c < 400 && k < n; c++) begin
      @(negedge clk_sys_in);
      act = pol[0] ? ~seg_display_out.strobe : seg_display_out.strobe;
      dat = pol[1] ? ~seg_display_out.data : seg_display_out.data;
      if ((act & ~mask) != 8'h00) begin
        chk("spare strobe", 32'h0, {24'h0, act & ~mask});
      end
      if ((act & mask) != 8'h00 && pact == 8'h00) begin
        chk("strobe", 32'h1 << k, {24'h0, act});
        chk("digit", {28'h0, bcd[4*k+:4]}, {28'h0, dat});
        chk("setup", {28'h0, pdat}, {28'h0, dat});
        chk("sign", {31'h0, neg}, {31'h0, seg_display_out.sign});
        if (k > 0) begin
          chk("spacing", 3 * OPD, c - last);
        end
        last = c;
        k++;
      end
      pact = act & mask;
      pdat = dat;
    end
    chk("digits shown", n, k);
    wr(ADDR_DISP_CFG, 32'h0);
  endtask

  task automatic t_scan(input logic [4:0] code, input logic [7:0] ms, input logic sg,
                        input logic ng, input logic [31:0] dig, input logic [31:0] exp,
                        input logic bad);
    int          n;
    int          held;
    logic        seen;
    logic [31:0] lo0;
    n = (code > 5'h10) ? int'(code) - 16 : int'(code);
    sw_signed <= sg;
    sw_neg    <= ng;
    sw_digits <= dig;
    wr(ADDR_SWITCH_TIME, {24'h0, ms});
    rd(ADDR_SCAN_LO, lo0);
    wr(ADDR_SCAN_CFG, {23'h0, 1'b1, 3'h0, code});
    held = 0;
    seen = 1'b0;
    for (int c = 0; c < 4000 && !(seen && scan_select_out == 8'h00); c++) begin
      @(negedge clk_sys_in);
      if (scan_select_out != 8'h00) begin
        seen = 1'b1;
        held++;
        if ($countones(scan_select_out) != 1) begin
          chk("select one-hot", 32'h1, $countones(scan_select_out));
        end
      end
    end
    chk("select time", n * int'(ms) * MSD, held);
    rd(ADDR_STATUS, rv);
    chk("done bad", {30'h0, bad, 1'b1}, {30'h0, rv[ST_SCAN_BAD], rv[ST_SCAN_DONE]});
    rd(ADDR_SCAN_LO, rv);
    chk("scan lo", bad ? lo0 : {16'h0, exp[15:0]}, rv);
    if (n > 4) begin
      rd(ADDR_SCAN_HI, rv);
      chk("scan hi", {16'h0, exp[31:16]}, rv);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset();
    t_disp(5'h02, 2'h0, 32'd57, 32'h57, 1'b0);
    t_disp(5'h04, 2'h1, 32'd9081, 32'h9081, 1'b0);
    t_disp(5'h05, 2'h2, 32'd12345, 32'h12345, 1'b0);
    t_disp(5'h08, 2'h3, 32'd98765432, 32'h98765432, 1'b0);
    t_disp(5'h12, 2'h0, 32'hFFFFFFDE, 32'h34, 1'b1);
    t_disp(5'h18, 2'h1, 32'hFFED2979, 32'h01234567, 1'b1);
    t_scan(5'h03, 8'h07, 1'b0, 1'b0, 32'h924, 32'd924, 1'b0);
    t_scan(5'h12, 8'h02, 1'b1, 1'b1, 32'h13, 32'hFFFFFFF3, 1'b0);
    t_scan(5'h06, 8'h01, 1'b0, 1'b0, 32'h123456, 32'd123456, 1'b0);
    t_scan(5'h02, 8'h01, 1'b0, 1'b0, 32'hA1, 32'h0, 1'b1);
    summarize();
  end
endmodule
